// ### hdl/temp_limit_pkg.sv
package temp_limit_pkg;
  // Command byte locations
  localparam logic [7:0] CMD_LOCAL_HIGH_RD = 8'h05;
  localparam logic [7:0] CMD_LOCAL_LOW_RD = 8'h06;
  localparam logic [7:0] CMD_REMOTE_HIGH_RD = 8'h07;
  localparam logic [7:0] CMD_REMOTE_LOW_RD = 8'h08;
  localparam logic [7:0] CMD_LOCAL_HIGH_WR = 8'h0B;
  localparam logic [7:0] CMD_LOCAL_LOW_WR = 8'h0C;
  localparam logic [7:0] CMD_REMOTE_HIGH_WR = 8'h0D;
  localparam logic [7:0] CMD_REMOTE_LOW_WR = 8'h0E;
  localparam logic [7:0] CMD_SINGLE_SHOT = 8'h0F;
  localparam logic [7:0] CMD_REMOTE_OFFSET_HIGH = 8'h11;
  localparam logic [7:0] CMD_REMOTE_OFFSET_LOW = 8'h12;
  localparam logic [7:0] CMD_REMOTE_HIGH_FRAC = 8'h13;
  localparam logic [7:0] CMD_REMOTE_LOW_FRAC = 8'h14;
  localparam logic [7:0] CMD_REMOTE_CRITICAL = 8'h19;
  localparam logic [7:0] CMD_LOCAL_CRITICAL = 8'h20;
  localparam logic [7:0] CMD_CRITICAL_HYST = 8'h21;
  localparam logic [7:0] CMD_ALERT_MODE = 8'hBF;
  localparam logic [7:0] CMD_MAKER_ID = 8'hFE;
  localparam logic [7:0] CMD_SILICON_REV = 8'hFF;

  // Values after reset
  localparam logic [7:0] HIGH_LIMIT_RESET = 8'h46;
  localparam logic [7:0] LOW_LIMIT_RESET = 8'h00;
  localparam logic [7:0] FRAC_RESET = 8'h00;
  localparam logic [7:0] CRITICAL_RESET = 8'h55;
  localparam logic [4:0] HYST_RESET = 5'h0A;
  localparam logic [7:0] OFFSET_RESET = 8'h00;
  localparam logic ALERT_MODE_RESET = 1'b0;

  // Field layouts
  localparam logic [7:0] FRAC_FIELD_MASK = 8'hE0;
  localparam logic [7:0] READ_ALL_ONES = 8'hFF;
  localparam int FLAG_LOCAL_HIGH = 6;
  localparam int FLAG_LOCAL_LOW = 5;
  localparam int FLAG_REMOTE_HIGH = 4;
  localparam int FLAG_REMOTE_LOW = 3;
  localparam int FLAG_OPEN = 2;
  localparam int FLAG_REMOTE_CRIT = 1;
  localparam int FLAG_LOCAL_CRIT = 0;
  // Flags that raise the alert: all but busy and open
  localparam logic [7:0] ALARM_FLAGS = 8'h7B;
endpackage : temp_limit_pkg

// ### hdl/temp_limit_alert_logic.sv
`timescale 1ns/1ps
// Functional notes
// - high limits reset to 70 degrees
// - remote high fraction upper three bits only
// - low limits and fraction reset to zero
// - critical limits signed byte, reset 85
// - hysteresis five low bits, reset ten
// - remote offset integer plus eighth fraction
// - alert mode bit zero selects comparator
// - alert mode bits seven to one zero
// - location FEh returns maker code
// - location FFh returns revision code
// - single shot in standby, one conversion
// - single shot stores nothing, reads ones
// - alert is open drain active low
// - compare each result, set matching flags
// - unmasked alarm flags drive alert low
// - interrupt and response modes behave alike
// - status read in interrupt mode clears flags, sets mask if an alarm flag was set
// - comparator mode releases when condition ends
// - response address answered, release, set mask
// - critical output with hysteresis release
module temp_limit_alert_logic import temp_limit_pkg::*; #(
  // Arbitrary identification values
  parameter logic [7:0] MAKER_CODE = 8'h5C,
  parameter logic [7:0] REVISION_CODE = 8'h03
) (
  // Core clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register access from the serial engine, link clock domain
  input wire logic link_clock,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [7:0] acc_cmd,
  input wire logic [7:0] acc_wdata,
  output logic acc_busy,
  output logic acc_done,
  output logic [7:0] acc_rdata,
  // Converter results
  input wire logic result_valid,
  input wire logic [7:0] local_temp,
  input wire logic [10:0] remote_temp,
  input wire logic diode_open,
  input wire logic standby,
  output logic conversion_start,
  // Configuration and status hooks
  input wire logic alert_mask,
  input wire logic local_crit_mask,
  input wire logic remote_crit_mask,
  input wire logic status_read,
  input wire logic ara_done,
  output logic mask_set_req,
  output logic [7:0] status_flags,
  // Open-drain pins
  output logic alert_out,
  output logic alert_oe,
  output logic critical_output,
  output logic critical_oe
);

  typedef struct packed {
    logic req_tog;
    logic write;
    logic [7:0] cmd;
    logic [7:0] wdata;
    logic ack_s1;
    logic ack_s2;
    logic ack_seen;
    logic busy;
    logic done;
    logic [7:0] rdata;
  } link_state_t;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic ack_tog;
    logic [7:0] rdata;
    logic [7:0] local_high_limit;
    logic [7:0] remote_high_limit_int;
    logic [7:0] remote_high_limit_frac;
    logic [7:0] local_low_limit;
    logic [7:0] remote_low_limit_int;
    logic [7:0] remote_low_limit_frac;
    logic [7:0] local_critical_limit;
    logic [7:0] remote_critical_limit;
    logic [4:0] critical_hysteresis;
    logic [7:0] remote_offset_high;
    logic [7:0] remote_offset_low;
    logic alert_mode_select;
    logic [7:0] flags;
    logic lcrit_act;
    logic rcrit_act;
    logic alert_drv;
    logic crit_drv;
    logic mask_req;
    logic shot;
  } core_state_t;

  link_state_t lk_reg, lk_next;
  core_state_t st_reg, st_next;

  // Link side: hold the request stable until the core answers
  always_comb begin
    lk_next = lk_reg;
    lk_next.ack_s1 = st_reg.ack_tog;
    lk_next.ack_s2 = lk_reg.ack_s1;
    lk_next.done = 1'b0;
    if (!lk_reg.busy && acc_valid) begin
      lk_next.req_tog = ~lk_reg.req_tog;
      lk_next.write = acc_write;
      lk_next.cmd = acc_cmd;
      lk_next.wdata = acc_wdata;
      lk_next.busy = 1'b1;
    end else if (lk_reg.busy && (lk_reg.ack_s2 != lk_reg.ack_seen)) begin
      lk_next.ack_seen = lk_reg.ack_s2;
      lk_next.busy = 1'b0;
      lk_next.done = 1'b1;
      lk_next.rdata = st_reg.rdata;
    end
  end

  always_ff @(posedge link_clock or negedge rst_n) begin
    if (!rst_n) begin
      lk_reg <= '0;
    end else begin
      lk_reg <= lk_next;
    end
  end

  // Remote reading corrected by the offset, in eighth degrees
  logic signed [10:0] remote_corr;
  logic [7:0] cond;
  logic req_new;
  logic signed [8:0] lcrit_release;
  logic signed [8:0] rcrit_release;

  always_comb begin
    remote_corr = $signed(remote_temp)
      + $signed({st_reg.remote_offset_high, st_reg.remote_offset_low[7:5]});
    lcrit_release = $signed({st_reg.local_critical_limit[7], st_reg.local_critical_limit})
      - $signed({4'h0, st_reg.critical_hysteresis});
    rcrit_release = $signed({st_reg.remote_critical_limit[7], st_reg.remote_critical_limit})
      - $signed({4'h0, st_reg.critical_hysteresis});
    // signed compares, fraction only where a fraction byte exists
    cond = 8'h00;
    cond[FLAG_LOCAL_HIGH] = $signed(local_temp) > $signed(st_reg.local_high_limit);
    cond[FLAG_LOCAL_LOW] = $signed(local_temp) < $signed(st_reg.local_low_limit);
    cond[FLAG_REMOTE_HIGH] = remote_corr
      > $signed({st_reg.remote_high_limit_int, st_reg.remote_high_limit_frac[7:5]});
    cond[FLAG_REMOTE_LOW] = remote_corr
      < $signed({st_reg.remote_low_limit_int, st_reg.remote_low_limit_frac[7:5]});
    cond[FLAG_OPEN] = diode_open;
    cond[FLAG_REMOTE_CRIT] = remote_corr > $signed({st_reg.remote_critical_limit, 3'h0});
    cond[FLAG_LOCAL_CRIT] = $signed(local_temp) > $signed(st_reg.local_critical_limit);
    req_new = st_reg.req_s2 != st_reg.req_seen;
  end

  always_comb begin
    st_next = st_reg;
    st_next.req_s1 = lk_reg.req_tog;
    st_next.req_s2 = st_reg.req_s1;
    st_next.shot = 1'b0;
    st_next.mask_req = 1'b0;

    // Command decode; the link holds cmd and data stable while busy
    if (req_new) begin
      st_next.req_seen = st_reg.req_s2;
      st_next.ack_tog = ~st_reg.ack_tog;
      if (lk_reg.write) begin
        unique case (lk_reg.cmd)
          CMD_LOCAL_HIGH_WR: st_next.local_high_limit = lk_reg.wdata;
          CMD_REMOTE_HIGH_WR: st_next.remote_high_limit_int = lk_reg.wdata;
          CMD_LOCAL_LOW_WR: st_next.local_low_limit = lk_reg.wdata;
          CMD_REMOTE_LOW_WR: st_next.remote_low_limit_int = lk_reg.wdata;
          CMD_REMOTE_HIGH_FRAC: st_next.remote_high_limit_frac = lk_reg.wdata & FRAC_FIELD_MASK;
          CMD_REMOTE_LOW_FRAC: st_next.remote_low_limit_frac = lk_reg.wdata & FRAC_FIELD_MASK;
          CMD_LOCAL_CRITICAL: st_next.local_critical_limit = lk_reg.wdata;
          CMD_REMOTE_CRITICAL: st_next.remote_critical_limit = lk_reg.wdata;
          CMD_CRITICAL_HYST: st_next.critical_hysteresis = lk_reg.wdata[4:0];
          CMD_REMOTE_OFFSET_HIGH: st_next.remote_offset_high = lk_reg.wdata;
          CMD_REMOTE_OFFSET_LOW: st_next.remote_offset_low = lk_reg.wdata & FRAC_FIELD_MASK;
          CMD_ALERT_MODE: st_next.alert_mode_select = lk_reg.wdata[0];
          // trigger only from standby; data dropped
          CMD_SINGLE_SHOT: st_next.shot = standby;
          default: st_next.shot = 1'b0;
        endcase
      end else begin
        unique case (lk_reg.cmd)
          CMD_LOCAL_HIGH_RD: st_next.rdata = st_reg.local_high_limit;
          CMD_REMOTE_HIGH_RD: st_next.rdata = st_reg.remote_high_limit_int;
          CMD_LOCAL_LOW_RD: st_next.rdata = st_reg.local_low_limit;
          CMD_REMOTE_LOW_RD: st_next.rdata = st_reg.remote_low_limit_int;
          CMD_REMOTE_HIGH_FRAC: st_next.rdata = st_reg.remote_high_limit_frac;
          CMD_REMOTE_LOW_FRAC: st_next.rdata = st_reg.remote_low_limit_frac;
          CMD_LOCAL_CRITICAL: st_next.rdata = st_reg.local_critical_limit;
          CMD_REMOTE_CRITICAL: st_next.rdata = st_reg.remote_critical_limit;
          CMD_CRITICAL_HYST: st_next.rdata = {3'h0, st_reg.critical_hysteresis};
          CMD_REMOTE_OFFSET_HIGH: st_next.rdata = st_reg.remote_offset_high;
          CMD_REMOTE_OFFSET_LOW: st_next.rdata = st_reg.remote_offset_low;
          CMD_ALERT_MODE: st_next.rdata = {7'h00, st_reg.alert_mode_select};
          CMD_MAKER_ID: st_next.rdata = MAKER_CODE;
          CMD_SILICON_REV: st_next.rdata = REVISION_CODE;
          // single shot and unmapped read all ones
          default: st_next.rdata = READ_ALL_ONES;
        endcase
      end
    end

    // status read in interrupt mode clears flags, requests mask if an alarm flag was set
    if (status_read && !st_reg.alert_mode_select) begin
      st_next.flags = 8'h00;
      st_next.mask_req = |(st_reg.flags & ALARM_FLAGS);
    end
    // answered response address releases alert and sets mask
    if (ara_done && st_reg.alert_drv) begin
      st_next.mask_req = 1'b1;
    end

    // new result sets flags; set wins over a same-cycle clear
    if (result_valid) begin
      // comparator mode flags track the present condition
      if (st_reg.alert_mode_select) begin
        st_next.flags = cond;
      end else begin
        st_next.flags = st_next.flags | cond;
      end
      // set above limit, release below limit minus hysteresis
      if (cond[FLAG_LOCAL_CRIT]) begin
        st_next.lcrit_act = 1'b1;
      end else if ($signed({local_temp[7], local_temp}) < lcrit_release) begin
        st_next.lcrit_act = 1'b0;
      end
      if (cond[FLAG_REMOTE_CRIT]) begin
        st_next.rcrit_act = 1'b1;
      end else if (remote_corr < $signed({rcrit_release, 3'h0})) begin
        st_next.rcrit_act = 1'b0;
      end
    end

    // interrupt and response modes share this path
    // mode bit only changes how flags clear and whether a status read requests the mask
    st_next.alert_drv = !alert_mask && !st_next.mask_req
      && |(st_next.flags & ALARM_FLAGS);
    st_next.crit_drv = (st_next.lcrit_act && !local_crit_mask)
      || (st_next.rcrit_act && !remote_crit_mask);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.local_high_limit <= HIGH_LIMIT_RESET;
      st_reg.remote_high_limit_int <= HIGH_LIMIT_RESET;
      st_reg.local_low_limit <= LOW_LIMIT_RESET;
      st_reg.remote_low_limit_int <= LOW_LIMIT_RESET;
      st_reg.remote_low_limit_frac <= FRAC_RESET;
      st_reg.remote_high_limit_frac <= FRAC_RESET;
      st_reg.local_critical_limit <= CRITICAL_RESET;
      st_reg.remote_critical_limit <= CRITICAL_RESET;
      st_reg.critical_hysteresis <= HYST_RESET;
      st_reg.remote_offset_high <= OFFSET_RESET;
      st_reg.remote_offset_low <= OFFSET_RESET;
      st_reg.alert_mode_select <= ALERT_MODE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops; alert_out and critical_output tied low
  assign acc_busy = lk_reg.busy;
  assign acc_done = lk_reg.done;
  assign acc_rdata = lk_reg.rdata;
  assign conversion_start = st_reg.shot;
  assign mask_set_req = st_reg.mask_req;
  assign status_flags = st_reg.flags;
  assign alert_out = 1'b0;
  assign alert_oe = st_reg.alert_drv;
  assign critical_output = 1'b0;
  assign critical_oe = st_reg.crit_drv;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  chk_shot_read_ones: assert property (
    req_new && !lk_reg.write && lk_reg.cmd == CMD_SINGLE_SHOT |=> st_reg.rdata == READ_ALL_ONES)
    else $error("single shot read not all ones");
  chk_mode_upper_zero: assert property (
    req_new && !lk_reg.write && lk_reg.cmd == CMD_ALERT_MODE |=> st_reg.rdata[7:1] == 7'h00)
    else $error("alert mode upper bits not zero");
  chk_shot_trigger: assert property (
    req_new && lk_reg.write && lk_reg.cmd == CMD_SINGLE_SHOT && standby
    |=> conversion_start ##1 !conversion_start)
    else $error("single shot did not give one start pulse");
  chk_alert_masked: assert property (
    alert_mask |=> !alert_oe)
    else $error("alert driven while masked");
  chk_high_flag_set: assert property (
    result_valid && cond[FLAG_LOCAL_HIGH] |=> status_flags[FLAG_LOCAL_HIGH])
    else $error("local high flag not set");
  chk_status_clear: assert property (
    status_read && !st_reg.alert_mode_select && !result_valid |=> status_flags == 8'h00)
    else $error("status read did not clear flags");
  chk_mask_on_read: assert property (
    status_read && !st_reg.alert_mode_select && |(status_flags & ALARM_FLAGS)
    |=> mask_set_req && !alert_oe)
    else $error("status read did not request mask");
  chk_comparator_release: assert property (
    st_reg.alert_mode_select && result_valid && (cond & ALARM_FLAGS) == 8'h00
    |=> !alert_oe)
    else $error("comparator alert not released");
  chk_crit_hold: assert property (
    st_reg.lcrit_act && !result_valid && !local_crit_mask |=> critical_oe)
    else $error("critical output dropped without new result");
  chk_ara_release: assert property (
    ara_done && alert_oe |=> mask_set_req && !alert_oe)
    else $error("response address did not release alert");

endmodule : temp_limit_alert_logic

// ### verif/host_model.sv
`timescale 1ns/1ps
module host_model (
  // Link side requests
  input wire logic link_clock,
  output logic acc_valid,
  output logic acc_write,
  output logic [7:0] acc_cmd,
  output logic [7:0] acc_wdata,
  // Link side answers
  input wire logic acc_busy,
  input wire logic acc_done,
  input wire logic [7:0] acc_rdata
);
  initial begin
    acc_valid = 1'b0;
    acc_write = 1'b1;
    acc_cmd = 8'hA5;
    acc_wdata = 8'h5A;
  end

  // Released lines show the inverse so stale data is never mistaken
  task automatic access(input logic wr, input logic [7:0] cmd, input logic [7:0] wd,
    input int gap, output logic [7:0] rd);
    int n;
    rd = 8'hXX;
    // Drive and sample on the falling edge, clear of the launching edge
    repeat (gap + 1) @(negedge link_clock);
    acc_valid = 1'b1;
    acc_write = wr;
    acc_cmd = cmd;
    acc_wdata = wd;
    @(negedge link_clock);
    acc_valid = 1'b0;
    acc_write = ~wr;
    acc_cmd = ~cmd;
    acc_wdata = ~wd;
    n = 0;
    do begin
      @(negedge link_clock);
      n++;
    end while (acc_done !== 1'b1 && n < 20);
    if (acc_done === 1'b1) rd = acc_rdata;
  endtask : access
endmodule : host_model

// ### verif/tb.sv
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0;
  logic link_clock = 1'b0;
  logic rst_n = 1'b0;
  logic acc_valid, acc_write, acc_busy, acc_done;
  logic [7:0] acc_cmd, acc_wdata, acc_rdata, status_flags, d;
  logic [7:0] local_temp = 8'h00;
  logic [10:0] remote_temp = 11'h000;
  logic result_valid = 1'b0, diode_open = 1'b0, standby = 1'b0, alert_mask = 1'b0;
  logic status_read = 1'b0, ara_done = 1'b0;
  logic conversion_start, mask_set_req, alert_out, alert_oe, critical_output, critical_oe;
  int checks = 0, mismatches = 0, starts = 0;
  // Write command, write data, read command, expected read
  logic [31:0] rows [29] = '{32'hFE000546, 32'hFE000600, 32'hFE000746, 32'hFE000800,
    32'hFE001300, 32'hFE001400, 32'hFE001955, 32'hFE002055, 32'hFE00210A, 32'hFE001100,
    32'hFE001200, 32'hFE00BF00, 32'hFE00FE5C, 32'hFE00FF03, 32'hFE000FFF, 32'hFE0050FF,
    32'h0D500750, 32'h0E800880, 32'h13FF13E0, 32'h14FF14E0, 32'h19601960, 32'h21FF211F,
    32'h210A210A, 32'h12FF12E0, 32'h11201120, 32'hBFFFBF01, 32'hBF00BF00, 32'h0F120FFF,
    32'h05110546};

  always #10 clock = ~clock;
  initial begin
    #7;
    forever #15 link_clock = ~link_clock;
  end
  always @(posedge clock) if (conversion_start === 1'b1) starts++;
  // Stand-in for the mask bit held in the configuration register
  always @(negedge clock) if (mask_set_req === 1'b1) alert_mask = 1'b1;

  host_model u_host (.link_clock(link_clock), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_cmd(acc_cmd), .acc_wdata(acc_wdata), .acc_busy(acc_busy), .acc_done(acc_done),
    .acc_rdata(acc_rdata));

  // Identification values are arbitrary
  temp_limit_alert_logic #(.MAKER_CODE(8'h5C), .REVISION_CODE(8'h03)) u_dut (
    .clock(clock), .rst_n(rst_n), .link_clock(link_clock), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_cmd(acc_cmd), .acc_wdata(acc_wdata), .acc_busy(acc_busy),
    .acc_done(acc_done), .acc_rdata(acc_rdata), .result_valid(result_valid),
    .local_temp(local_temp), .remote_temp(remote_temp), .diode_open(diode_open),
    .standby(standby), .conversion_start(conversion_start), .alert_mask(alert_mask),
    .local_crit_mask(1'b0), .remote_crit_mask(1'b0), .status_read(status_read),
    .ara_done(ara_done), .mask_set_req(mask_set_req), .status_flags(status_flags),
    .alert_out(alert_out), .alert_oe(alert_oe), .critical_output(critical_output),
    .critical_oe(critical_oe));

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic chk1(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1

  task automatic conv(input logic [7:0] lt, input logic [7:0] rt, input logic dio,
    input logic [7:0] ef, input logic ea, input logic ec);
    @(negedge clock);
    local_temp = lt;
    remote_temp = {rt, 3'b000};
    diode_open = dio;
    result_valid = 1'b1;
    @(negedge clock);
    result_valid = 1'b0;
    chk8("status_flags", ef, status_flags);
    chk1("alert_oe", ea, alert_oe);
    chk1("critical_oe", ec, critical_oe);
  endtask : conv

  task automatic sread(input logic [7:0] ef, input logic er, input logic ea);
    @(negedge clock);
    status_read = 1'b1;
    @(negedge clock);
    status_read = 1'b0;
    chk8("status_flags", ef, status_flags);
    chk1("mask_set_req", er, mask_set_req);
    chk1("alert_oe", ea, alert_oe);
  endtask : sread

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  initial begin
    #300000;
    mismatches++;
    final_report();
  end

  initial begin
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    chk8("status_flags", 8'h00, status_flags);
    chk1("alert_oe", 1'b0, alert_oe);
    chk1("critical_oe", 1'b0, critical_oe);
    chk1("critical_output", 1'b0, critical_output);
    chk1("acc_busy", 1'b0, acc_busy);
    for (int i = 0; i < 29; i++) begin
      u_host.access(1'b1, rows[i][31:24], rows[i][23:16], 0, d);
      u_host.access(1'b0, rows[i][15:8], 8'h00, i % 3, d);
      chk8("readback", rows[i][7:0], d);
    end
    chk8("starts", 8'h00, 8'(starts));
    conv(8'h14, 8'h14, 1'b0, 8'h00, 1'b0, 1'b0);
    conv(8'h50, 8'h14, 1'b0, 8'h40, 1'b1, 1'b0);
    chk1("alert_out", 1'b0, alert_out);
    conv(8'h14, 8'h14, 1'b0, 8'h40, 1'b1, 1'b0);
    sread(8'h00, 1'b1, 1'b0);
    conv(8'h50, 8'h14, 1'b0, 8'h40, 1'b0, 1'b0);
    sread(8'h00, 1'b1, 1'b0);
    @(negedge clock);
    alert_mask = 1'b0;
    conv(8'hF0, 8'h14, 1'b0, 8'h20, 1'b1, 1'b0);
    @(negedge clock);
    ara_done = 1'b1;
    @(negedge clock);
    ara_done = 1'b0;
    chk1("mask_set_req", 1'b1, mask_set_req);
    chk1("alert_oe", 1'b0, alert_oe);
    chk8("status_flags", 8'h20, status_flags);
    sread(8'h00, 1'b1, 1'b0);
    @(negedge clock);
    alert_mask = 1'b0;
    conv(8'h14, 8'h14, 1'b1, 8'h04, 1'b0, 1'b0);
    sread(8'h00, 1'b0, 1'b0);
    conv(8'h56, 8'h14, 1'b0, 8'h41, 1'b1, 1'b1);
    conv(8'h4B, 8'h14, 1'b0, 8'h41, 1'b1, 1'b1);
    conv(8'h4A, 8'h14, 1'b0, 8'h41, 1'b1, 1'b0);
    sread(8'h00, 1'b1, 1'b0);
    @(negedge clock);
    alert_mask = 1'b0;
    u_host.access(1'b1, 8'hBF, 8'h01, 0, d);
    conv(8'h50, 8'h14, 1'b0, 8'h40, 1'b1, 1'b0);
    sread(8'h40, 1'b0, 1'b1);
    conv(8'h14, 8'h14, 1'b0, 8'h00, 1'b0, 1'b0);
    conv(8'h14, 8'h3C, 1'b0, 8'h10, 1'b1, 1'b0);
    conv(8'h14, 8'h14, 1'b0, 8'h00, 1'b0, 1'b0);
    u_host.access(1'b1, 8'hBF, 8'h00, 0, d);
    @(negedge clock);
    standby = 1'b1;
    u_host.access(1'b1, 8'h0F, 8'hA5, 0, d);
    repeat (10) @(negedge clock);
    chk8("starts", 8'h01, 8'(starts));
    final_report();
  end
endmodule : tb
